/* File: i2c_master_model.sv */
/* Behavioural two-wire bus master with an 80 ns bit clock.
   Assumes pull-ups: a released line reads high. */
`timescale 1ns/1ps
module i2c_master_model (
    // Resolved line levels
    input wire scl,
    input wire sda,
    // Pull-down requests
    output reg scl_low,
    output reg sda_low,
    // Clock stretch outlasted the bound
    output reg stuck
);
    integer n;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        stuck = 1'b0;
    end
    // Release SCL and wait out any stretch
    task rise;
        begin
            scl_low = 1'b0;
            // Let the wired line settle so an unstretched bit costs no time
            #0;
            for (n = 0; n < 4000 && !scl; n = n + 1) #8;
            if (!scl) stuck = 1'b1;
        end
    endtask
    // SDA falls while SCL is high
    task start;
        begin
            // Start off the sampling edge of the system clock
            #2;
            sda_low = 1'b0;
            rise;
            #40 sda_low = 1'b1;
            #40 scl_low = 1'b1;
        end
    endtask
    // SDA rises while SCL is high
    task stop;
        begin
            // Start off the sampling edge of the system clock
            #22 sda_low = 1'b1;
            #20 rise;
            #40 sda_low = 1'b0;
            #40;
        end
    endtask
    // Nine bits MSB first; a released bit reads the slave
    task xfer(input [8:0] o, output [8:0] i);
        integer k;
        begin
            // Start off the sampling edge of the system clock
            #2;
            for (k = 8; k >= 0; k = k - 1) begin
                sda_low = !o[k];
                #20 rise;
                #20 i[k] = sda;
                #20 scl_low = 1'b1;
                #20;
            end
        end
    endtask
endmodule

/* File: i2c_slave_defines.vh */
/*
 * Constants for the two-wire slave block: register offsets, field
 * positions, reset values and mode codes.
 * Assumes inclusion by bare name from the slave module.
 */
`ifndef I2C_SLAVE_DEFINES_VH
`define I2C_SLAVE_DEFINES_VH

// Register byte offsets on the AHB-Lite bus
`define OFS_CTRL0 8'h00
`define OFS_STATUS 8'h04
`define OFS_DATA 8'h08
`define OFS_ADDR 8'h0c
`define OFS_TIMEOUT 8'h10

// Status/control register fields
`define ST_XFER_DONE 7
`define ST_ADDR_MATCH 6
`define ST_BUS_BUSY 5
`define ST_TX_SELECT 4
`define ST_ACK_OUT 3
`define ST_RW_DIR 2
`define ST_WAKE_EN 1
`define ST_ACK_IN 0
`define STATUS_RESET 8'h81

// Control register 0 fields
`define C0_MODE_HI 7
`define C0_MODE_LO 5
`define C0_ENABLE 1
`define CTRL0_RESET 8'he0
`define MODE_I2C_SLAVE 3'h6

// Time-out control fields
`define TO_ENABLE 7
`define TO_FLAG 6

// Address register reset value
`define ADDR_RESET 8'h00

`endif

/* File: i2c_slave_status_protocol.v */
/*
 * Slave-only two-wire serial interface with AHB-Lite register access.
 * Assumes SDA/SCL pads are open drain with external pull-ups; the pads
 * are asynchronous and pass two flip-flops before any logic reads them.
 * The time-out counter sits outside; only its overflow pulse enters.
 */
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
// Overview of operation
// - Transfer flag low during byte, high after
// - START clears transfer-complete flag
// - Software data read clears transfer-complete flag
// - STOP sets transfer-complete flag
// - Address flag follows own address comparison
// - Busy set on START, cleared on STOP
// - START is SDA fall while SCL high
// - Direction bit selects receive or transmit
// - Ninth clock drives programmed acknowledge bit
// - Software clears acknowledge bit before receiving
// - Eighth bit stored as read/write flag
// - Seven address bits MSB first compared
// - Address match raises serial interrupt
// - Matched address acknowledged low on ninth bit
// - Hold SCL low after address ack and acked sent bytes until data access
// - Ninth clock samples master acknowledge
// - Send while acked, release on no ack
// - Address match wakes core when enabled
// - One interrupt shared by three sources
// - Init: mode 110, enable, address, interrupt
// - Enable rising resets status flags only
// - Time-out stops counter, clears enable, flags
`timescale 1ns/1ps
`include "i2c_slave_defines.vh"

module i2c_slave_status_protocol (
    // System clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // Two-wire pads
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Time-out counter link and system outputs
    input wire timeout_pulse,
    input wire serial_irq_enable,
    input wire core_asleep,
    output wire serial_irq,
    output wire wake_req
);

    // Bus states of the byte engine
    localparam S_IDLE = 3'd0;
    localparam S_ADDR = 3'd1;
    localparam S_AACK = 3'd2;
    localparam S_RX = 3'd3;
    localparam S_RACK = 3'd4;
    localparam S_TX = 3'd5;
    localparam S_TACK = 3'd6;
    localparam S_WAIT = 3'd7;

    // Pad synchronisers and previous samples
    reg scl_m_q, scl_s_q, scl_p_q;
    reg sda_m_q, sda_s_q, sda_p_q;
    // Software registers
    reg [7:0] ctrl0_q;
    reg [7:0] own_addr_reg_q;
    reg [7:0] serial_data_reg_q;
    reg timeout_enable_q;
    reg timeout_flag_q;
    // Status bits
    reg xfer_done_flag_q;
    reg addr_match_flag_q;
    reg bus_busy_flag_q;
    reg slave_tx_select_q;
    reg ack_out_bit_q;
    reg rw_dir_flag_q;
    reg match_wake_enable_q;
    reg ack_in_flag_q;
    // Engine state
    reg [2:0] state_q;
    reg [3:0] bit_cnt_q;
    reg [7:0] shift_q;
    reg sda_low_q;
    reg scl_hold_q;
    reg irq_pulse_q;
    reg enable_p_q;
    // Bus data phase registers
    reg dp_wr_q, dp_rd_q;
    reg [7:0] dp_addr_q;
    reg [31:0] hrdata_q;

    // Pad edge and condition decode
    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    wire i2c_on = ctrl0_q[`C0_ENABLE] &
        (ctrl0_q[`C0_MODE_HI:`C0_MODE_LO] == `MODE_I2C_SLAVE);
    wire enable_rise = i2c_on & ~enable_p_q;

    // Bus request decode
    wire take = hsel & hready & htrans[1];
    wire wr_st = dp_wr_q & (dp_addr_q == `OFS_STATUS);
    wire wr_data = dp_wr_q & (dp_addr_q == `OFS_DATA);
    wire rd_data = dp_rd_q & (dp_addr_q == `OFS_DATA);

    // Single-cycle zero-wait OKAY slave
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Open-drain pads drive only low
    assign sda_out = 1'b0;
    assign sda_oe = sda_low_q;
    assign scl_out = 1'b0;
    assign scl_oe = scl_hold_q;

    // Shared interrupt and wake request
    assign serial_irq = irq_pulse_q & serial_irq_enable;
    assign wake_req = match_wake_enable_q & addr_match_flag_q & core_asleep;

    // Two-stage pad synchronisers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            enable_p_q <= 1'b0;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            enable_p_q <= i2c_on;
        end
    end

    // Bus address phase capture
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_rd_q <= 1'b0;
            dp_addr_q <= 8'h00;
        end else begin
            dp_wr_q <= take & hwrite;
            dp_rd_q <= take & ~hwrite;
            if (take) begin
                dp_addr_q <= haddr;
            end
        end
    end

    // Read mux, registered at the address phase
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (take & ~hwrite) begin
            case (haddr)
                `OFS_CTRL0: hrdata_q <= {24'h000000, ctrl0_q};
                `OFS_STATUS: hrdata_q <= {24'h000000, xfer_done_flag_q,
                    addr_match_flag_q, bus_busy_flag_q, slave_tx_select_q,
                    ack_out_bit_q, rw_dir_flag_q, match_wake_enable_q,
                    ack_in_flag_q};
                `OFS_DATA: hrdata_q <= {24'h000000, serial_data_reg_q};
                `OFS_ADDR: hrdata_q <= {24'h000000, own_addr_reg_q};
                `OFS_TIMEOUT: hrdata_q <= {24'h000000, timeout_enable_q,
                    timeout_flag_q, 6'h00};
                default: hrdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Software-owned configuration registers
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl0_q <= `CTRL0_RESET;
            own_addr_reg_q <= `ADDR_RESET;
            timeout_enable_q <= 1'b0;
            timeout_flag_q <= 1'b0;
        end else begin
            if (dp_wr_q & (dp_addr_q == `OFS_CTRL0)) begin
                ctrl0_q <= {hwdata[7:5], 1'b0, hwdata[3:0]};
            end
            if (dp_wr_q & (dp_addr_q == `OFS_ADDR)) begin
                own_addr_reg_q <= hwdata[7:0];
            end
            // Overflow wins over software clear
            if (timeout_pulse & timeout_enable_q) begin
                timeout_enable_q <= 1'b0;
                timeout_flag_q <= 1'b1;
            end else if (dp_wr_q & (dp_addr_q == `OFS_TIMEOUT)) begin
                timeout_enable_q <= hwdata[`TO_ENABLE];
                timeout_flag_q <= hwdata[`TO_FLAG];
            end
        end
    end

    // Byte engine, status flags and data register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= S_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            sda_low_q <= 1'b0;
            scl_hold_q <= 1'b0;
            irq_pulse_q <= 1'b0;
            serial_data_reg_q <= 8'h00;
            xfer_done_flag_q <= 1'b1;
            addr_match_flag_q <= 1'b0;
            bus_busy_flag_q <= 1'b0;
            slave_tx_select_q <= 1'b0;
            ack_out_bit_q <= 1'b0;
            rw_dir_flag_q <= 1'b0;
            match_wake_enable_q <= 1'b0;
            ack_in_flag_q <= 1'b1;
        end else begin
            irq_pulse_q <= 1'b0;
            // Writable control bits only; flags ignore writes
            if (wr_st) begin
                slave_tx_select_q <= hwdata[`ST_TX_SELECT];
                ack_out_bit_q <= hwdata[`ST_ACK_OUT];
                match_wake_enable_q <= hwdata[`ST_WAKE_EN];
            end
            // Software data access
            if (wr_data) begin
                serial_data_reg_q <= hwdata[7:0];
            end
            if (rd_data) begin
                xfer_done_flag_q <= 1'b0;
            end
            // Release clock hold on data access
            if ((wr_data | rd_data) & scl_hold_q) begin
                scl_hold_q <= 1'b0;
                if (slave_tx_select_q) begin
                    shift_q <= wr_data ? hwdata[7:0] : serial_data_reg_q;
                end
            end
            if (!i2c_on || enable_rise || (timeout_pulse & timeout_enable_q)) begin
                // Engine to idle; flags to defaults on enable rise or time-out, control bits kept
                state_q <= S_IDLE;
                sda_low_q <= 1'b0;
                scl_hold_q <= 1'b0;
                if (enable_rise || (timeout_pulse & timeout_enable_q)) begin
                    xfer_done_flag_q <= 1'b1;
                    addr_match_flag_q <= 1'b0;
                    bus_busy_flag_q <= 1'b0;
                    rw_dir_flag_q <= 1'b0;
                    ack_in_flag_q <= 1'b1;
                    irq_pulse_q <= timeout_pulse;
                end
            end else if (start_det) begin
                // Master-only START begins address phase
                state_q <= S_ADDR;
                bit_cnt_q <= 4'h0;
                xfer_done_flag_q <= 1'b0;
                bus_busy_flag_q <= 1'b1;
                addr_match_flag_q <= 1'b0;
                sda_low_q <= 1'b0;
            end else if (stop_det) begin
                state_q <= S_IDLE;
                xfer_done_flag_q <= 1'b1;
                bus_busy_flag_q <= 1'b0;
                sda_low_q <= 1'b0;
                scl_hold_q <= 1'b0;
            end else begin
                case (state_q)
                    S_ADDR: begin
                        // Shift address then direction bit
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            if (shift_q[7:1] == own_addr_reg_q[7:1]) begin
                                addr_match_flag_q <= 1'b1;
                                rw_dir_flag_q <= shift_q[0];
                                irq_pulse_q <= 1'b1;
                                sda_low_q <= 1'b1;
                                state_q <= S_AACK;
                            end else begin
                                addr_match_flag_q <= 1'b0;
                                state_q <= S_WAIT;
                            end
                        end
                    end
                    S_AACK: begin
                        // After ack clock, hold SCL for service
                        if (scl_fall) begin
                            scl_hold_q <= 1'b1;
                            state_q <= rw_dir_flag_q ? S_TX : S_RX;
                            sda_low_q <= 1'b0;
                        end
                    end
                    S_RX: begin
                        // Receive one byte MSB first
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s_q};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end
                        if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            serial_data_reg_q <= shift_q;
                            xfer_done_flag_q <= 1'b1;
                            irq_pulse_q <= 1'b1;
                            sda_low_q <= ~ack_out_bit_q;
                            state_q <= S_RACK;
                        end else if (scl_fall) begin
                            xfer_done_flag_q <= 1'b0;
                        end
                    end
                    S_RACK: begin
                        // Release ack at end of ninth clock
                        if (scl_fall) begin
                            sda_low_q <= 1'b0;
                            state_q <= S_RX;
                        end
                    end
                    S_TX: begin
                        // Drive bits on SCL low, MSB first
                        if (!scl_hold_q && !scl_s_q && bit_cnt_q < 4'h8) begin
                            sda_low_q <= ~shift_q[7];
                        end
                        if (scl_fall) begin
                            shift_q <= {shift_q[6:0], 1'b1};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            xfer_done_flag_q <= 1'b0;
                            if (bit_cnt_q == 4'h7) begin
                                sda_low_q <= 1'b0;
                                state_q <= S_TACK;
                            end
                        end
                    end
                    S_TACK: begin
                        // Sample master ack on ninth clock
                        if (scl_rise) begin
                            ack_in_flag_q <= sda_s_q;
                        end
                        if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            xfer_done_flag_q <= 1'b1;
                            irq_pulse_q <= 1'b1;
                            if (ack_in_flag_q) begin
                                state_q <= S_WAIT;
                            end else begin
                                scl_hold_q <= 1'b1;
                                state_q <= S_TX;
                            end
                        end
                    end
                    S_WAIT: begin
                        // SDA released, await STOP or repeated START
                        sda_low_q <= 1'b0;
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

/* File: i2c_slave_status_protocol_assertions.sv */
/* Concurrent checks on the two-wire slave block's ports.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/1ps
module i2c_slave_chk (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Bus side
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hresp,
    // Pads and system pins
    input wire scl_in,
    input wire scl_out,
    input wire scl_oe,
    input wire sda_out,
    input wire sda_oe,
    input wire timeout_pulse,
    input wire serial_irq_enable,
    input wire core_asleep,
    input wire serial_irq,
    input wire wake_req
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Accepted bus request
    wire take = hsel && hready && htrans[1];
    // Cycles since the last request or time-out, saturating
    reg [3:0] age_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) age_q <= 4'hf;
        else if (take || timeout_pulse) age_q <= 4'h0;
        else if (age_q != 4'hf) age_q <= age_q + 4'h1;
    end
    chk_unmapped_zero: assert property (
        take && !hwrite && haddr > 8'h10 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_resp_okay: assert property (hresp == 1'b0) // Bus answer always OKAY
        else $error("error response on bus");
    chk_open_drain: assert property (!scl_out && !sda_out)
        else $error("pad drives high");
    chk_irq_gated: assert property (serial_irq |-> serial_irq_enable)
        else $error("interrupt while disabled");
    chk_irq_pulse: assert property (serial_irq |=> !serial_irq)
        else $error("interrupt longer than a cycle");
    chk_wake_cause: assert property ($rose(wake_req) |-> core_asleep)
        else $error("wake while awake");
    chk_sda_scl_low: assert property ($changed(sda_oe) |-> !$past(scl_in))
        else $error("data changed with clock high");
    chk_sda_bounded: assert property ($rose(sda_oe) |-> ##[1:300] !sda_oe)
        else $error("data line held too long");
    chk_hold_start: assert property ($rose(scl_oe) |-> !$past(scl_in))
        else $error("stretch began with clock high");
    chk_hold_end: assert property ($fell(scl_oe) |-> age_q <= 4'h6)
        else $error("stretch ended without access");
    cover property (serial_irq);
    cover property (wake_req);
    cover property ($fell(scl_oe));
endmodule
bind i2c_slave_status_protocol i2c_slave_chk u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hresp(hresp), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe), .timeout_pulse(timeout_pulse),
    .serial_irq_enable(serial_irq_enable), .core_asleep(core_asleep),
    .serial_irq(serial_irq), .wake_req(wake_req));

/* File: i2c_slave_status_protocol_tb.sv */
/* Bench for the two-wire slave: AHB-Lite register tasks and a bus master.
   Assumes pull-ups on both lines and the defines header offsets. */
`timescale 1ns/1ps
`include "i2c_slave_defines.vh"
`define CHK(n, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
    num_errors = num_errors + 1; $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module i2c_slave_status_protocol_tb;
    reg hclk, hresetn, hsel, hwrite, timeout_pulse, core_asleep, irq_en;
    reg [7:0] haddr;
    reg [1:0] htrans;
    reg [31:0] hwdata, rd;
    reg [8:0] got;
    wire [31:0] hrdata;
    wire hreadyout, scl_oe, sda_oe, serial_irq, wake_req, m_scl, m_sda, stuck;
    // Wired-AND lines with pull-ups
    wire scl = !(scl_oe || m_scl);
    wire sda = !(sda_oe || m_sda);
    integer num_errors = 0, total_checks = 0, irq_n = 0, base;
    i2c_slave_status_protocol uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .timeout_pulse(timeout_pulse), .serial_irq_enable(irq_en),
        .core_asleep(core_asleep), .serial_irq(serial_irq), .wake_req(wake_req));
    i2c_master_model m (.scl(scl), .sda(sda), .scl_low(m_scl), .sda_low(m_sda),
        .stuck(stuck));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    // Interrupt pulse counter
    always @(posedge hclk) if (serial_irq === 1'b1) irq_n <= irq_n + 1;
    task summarize;
        begin
            $display("checks %0d errors %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    // Bounded wait for hready at a rising edge
    task wait_ready;
        integer k;
        begin
            for (k = 0; k < 20; k = k + 1) begin
                @(posedge hclk);
                if (hreadyout === 1'b1) k = 99;
            end
            if (k != 100) begin
                num_errors = num_errors + 1;
                summarize;
            end
        end
    endtask
    // One single transfer: address phase, then data phase
    task ahb(input w, input [7:0] a, input [31:0] wd);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            wait_ready;
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
            wait_ready;
            rd = hrdata;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        ahb(1'b1, a, {24'h0, d});
    endtask
    // Read and compare the masked low byte; upper bits must be zero
    task rchk(input [7:0] a, input [7:0] e, input [7:0] mk);
        begin
            ahb(1'b0, a, 32'h0);
            `CHK($sformatf("reg %h", a), {24'h0, e & mk}, rd & {24'hffffff, mk})
        end
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwdata = 32'h0;
        timeout_pulse = 1'b0;
        core_asleep = 1'b0;
        irq_en = 1'b1;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values and an unmapped place
        rchk(`OFS_STATUS, `STATUS_RESET, 8'hff);
        rchk(`OFS_CTRL0, `CTRL0_RESET, 8'hff);
        rchk(`OFS_TIMEOUT, 8'h00, 8'hff);
        rchk(8'h14, 8'h00, 8'hff);
        // Slave mode, own address 0x52
        wr(`OFS_CTRL0, 8'hc2);
        wr(`OFS_ADDR, 8'ha4);
        rchk(`OFS_ADDR, 8'ha4, 8'hff);
        wr(`OFS_STATUS, 8'hff);
        rchk(`OFS_STATUS, 8'h9b, 8'hff);
        wr(`OFS_STATUS, 8'h00);
        // Foreign address is ignored
        m.start;
        rchk(`OFS_STATUS, 8'h20, 8'he0);
        m.xfer(9'h0cd, got);
        `CHK("foreign ack", 1'b1, got[0])
        rchk(`OFS_STATUS, 8'h00, 8'h40);
        m.stop;
        rchk(`OFS_STATUS, 8'h80, 8'ha0);
        // Matched write, wake enabled while asleep
        wr(`OFS_STATUS, 8'h02);
        core_asleep <= 1'b1;
        base = irq_n;
        m.start;
        m.xfer(9'h149, got);
        `CHK("addr ack", 1'b0, got[0])
        `CHK("match irq", 1, irq_n - base)
        `CHK("wake", 1'b1, wake_req)
        rchk(`OFS_STATUS, 8'h62, 8'h66);
        wr(`OFS_STATUS, 8'h00);
        rchk(`OFS_DATA, 8'h00, 8'h00);
        `CHK("wake off", 1'b0, wake_req)
        base = irq_n;
        m.xfer(9'h0b5, got);
        `CHK("data ack", 1'b0, got[0])
        `CHK("byte irq", 1, irq_n - base)
        rchk(`OFS_STATUS, 8'h80, 8'h80);
        rchk(`OFS_DATA, 8'h5a, 8'hff);
        rchk(`OFS_STATUS, 8'h00, 8'h80);
        wr(`OFS_STATUS, 8'h08);
        // Byte done with the interrupt pin masked
        irq_en <= 1'b0;
        base = irq_n;
        m.xfer(9'h079, got);
        `CHK("data nack", 1'b1, got[0])
        `CHK("irq masked", 0, irq_n - base)
        irq_en <= 1'b1;
        rchk(`OFS_DATA, 8'h3c, 8'hff);
        wr(`OFS_STATUS, 8'h00);
        m.stop;
        // Matched read: slave transmits until no acknowledge
        wr(`OFS_STATUS, 8'h10);
        m.start;
        m.xfer(9'h14b, got);
        `CHK("read ack", 1'b0, got[0])
        rchk(`OFS_STATUS, 8'h54, 8'h54);
        wr(`OFS_DATA, 8'h96);
        m.xfer(9'h1fe, got);
        `CHK("tx byte", 8'h96, got[8:1])
        rchk(`OFS_STATUS, 8'h00, 8'h01);
        wr(`OFS_DATA, 8'h0f);
        m.xfer(9'h1ff, got);
        `CHK("tx byte", 8'h0f, got[8:1])
        rchk(`OFS_STATUS, 8'h01, 8'h01);
        `CHK("sda free", 1'b1, sda)
        m.stop;
        // Time-out while matched
        wr(`OFS_STATUS, 8'h00);
        m.start;
        m.xfer(9'h149, got);
        wr(`OFS_TIMEOUT, 8'h80);
        base = irq_n;
        timeout_pulse <= 1'b1;
        @(posedge hclk);
        timeout_pulse <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK("timeout irq", 1, irq_n - base)
        rchk(`OFS_TIMEOUT, 8'h40, 8'hc0);
        rchk(`OFS_STATUS, `STATUS_RESET, 8'hff);
        m.stop;
        // Wrong mode code keeps the interface idle
        wr(`OFS_CTRL0, 8'he2);
        m.start;
        rchk(`OFS_STATUS, 8'h00, 8'h20);
        m.stop;
        wr(`OFS_CTRL0, 8'hc2);
        // Enable off then on while busy
        m.start;
        wr(`OFS_STATUS, 8'h10);
        rchk(`OFS_STATUS, 8'h30, 8'h30);
        wr(`OFS_CTRL0, 8'hc0);
        wr(`OFS_CTRL0, 8'hc2);
        rchk(`OFS_STATUS, 8'h91, 8'hff);
        m.stop;
        `CHK("stretch", 1'b0, stuck)
        summarize;
    end
endmodule
